// *** hdl/ocs_clock_select.sv ***
// clock source supervision and selection top level
`timescale 1ns/1ps
module ocs_clock_select
  import ocs_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // pins and config
  input wire logic crystal_input,
  input wire logic [2:0] clock_mode_straps,
  input wire logic osc_supervisor_disable,
  input wire logic irq_clear,
  // status
  output logic owd_irq,
  output logic clk_switched,
  output logic pll_power_on,
  output logic use_pll,
  output logic use_prescaler,
  output logic cpu_clk_sel_free,
  output logic [2:0] pll_in_div,
  output logic [7:0] pll_vco_mul,
  output logic [2:0] pll_vco_div,
  output logic [4:0] pll_factor,
  output logic [4:0] wd_count
);
  // decode strap code into pll setting
  function automatic ocs_pll_t decode(input logic [2:0] s);
    ocs_pll_t p;
    p = '{1'b1, 1'b0, PLL_DEF_PRE, PLL_DEF_MUL, PLL_DEF_DIV, PLL_DEF_F};
    case (s)
      3'h7: p = '{1'b1, 1'b0, 3'h4, 8'h40, 3'h4, 5'h04};
      3'h6: p = '{1'b1, 1'b0, 3'h4, 8'h30, 3'h4, 5'h03};
      3'h5: p = '{1'b1, 1'b0, 3'h4, 8'h40, 3'h2, 5'h08};
      3'h4: p = '{1'b1, 1'b0, 3'h4, 8'h28, 3'h2, 5'h05};
      3'h2: p = '{1'b1, 1'b0, 3'h2, 8'h28, 3'h2, 5'h0a};
      3'h0: p = '{1'b1, 1'b0, 3'h2, 8'h40, 3'h2, 5'h10};
      3'h3: p = '{1'b0, 1'b0, 3'h1, 8'h01, 3'h1, 5'h01};
      3'h1: p = '{1'b0, 1'b1, 3'h1, 8'h01, 3'h1, 5'h01};
      default: p = '{1'b1, 1'b0, PLL_DEF_PRE, PLL_DEF_MUL, PLL_DEF_DIV, PLL_DEF_F};
    endcase
    return p;
  endfunction : decode
  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [1:0] xs_q; // crystal input two-stage sync
  logic [1:0] xs_d;
  logic xprev_q; // previous synced level for edge detection
  logic xprev_d;
  logic [2:0] st1_q; // strap sync first stage
  logic [2:0] st2_q; // strap sync second stage
  logic [2:0] st1_d;
  logic [2:0] st2_d;
  always_comb begin
    xs_d = {xs_q[0], crystal_input};
    xprev_d = xs_q[1];
    st1_d = clock_mode_straps;
    st2_d = st1_q;
  end
  always_ff @(posedge mclk) begin
    xs_q <= xs_d;
    xprev_q <= xprev_d;
    st1_q <= st1_d;
    st2_q <= st2_d;
  end
  ////////////////////////////////////////////////////////////////////////////
  // strap capture and source state
  logic [2:0] strap_q; // straps latched while in reset
  logic [2:0] strap_d;
  ocs_src_t src_q; // clock source state
  ocs_src_t src_d;
  logic irq_q; // sticky interrupt flag
  logic irq_d;
  logic dis_q; // registered disable bit
  logic dis_d;
  ocs_pll_t cfg; // decoded setting
  logic supervise; // watchdog active
  ocs_wd_if wd ();
  assign cfg = decode(strap_q);
  // supervision only without pll multiply and when enabled
  assign supervise = !dis_q && !cfg.pll_on && (src_q == CS_EXT);
  // next state
  always_comb begin
    strap_d = strap_q;
    src_d = src_q;
    irq_d = irq_q;
    dis_d = osc_supervisor_disable;
    case (src_q)
      CS_RESET: begin
        src_d = CS_EXT;
      end
      CS_EXT: begin
        if (wd.ovf && supervise) begin
          src_d = CS_FREE;
        end
      end
      CS_FREE: begin
        src_d = CS_FREE;
      end
      default: src_d = CS_RESET;
    endcase
    if (irq_clear) begin
      irq_d = 1'b0;
    end
    if (src_q == CS_EXT && wd.ovf && supervise) begin
      irq_d = 1'b1;
    end
  end
  // register state; reset returns source to direct input
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      strap_q <= st2_q;
      src_q <= CS_RESET;
      irq_q <= 1'b0;
      dis_q <= CFG_DIS_RST;
    end else begin
      strap_q <= strap_d;
      src_q <= src_d;
      irq_q <= irq_d;
      dis_q <= dis_d;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // watchdog counter
  assign wd.run = supervise;
  assign wd.xtal_edge = xs_q[1] ^ xprev_q;
  ocs_wd_counter u_cnt (
    .mclk(mclk),
    .rst_n(rst_n),
    .wd(wd)
  );
  ////////////////////////////////////////////////////////////////////////////
  // outputs
  logic [4:0] cnt_q; // registered count copy
  logic pwr_q; // registered pll power
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cnt_q <= WD_ZERO;
      pwr_q <= 1'b0;
    end else begin
      cnt_q <= wd.count;
      pwr_q <= cfg.pll_on || !dis_q;
    end
  end
  assign owd_irq = irq_q;
  assign clk_switched = (src_q == CS_FREE);
  assign cpu_clk_sel_free = (src_q == CS_FREE);
  assign pll_power_on = pwr_q;
  assign use_pll = cfg.pll_on;
  assign use_prescaler = cfg.presc_out;
  assign pll_in_div = cfg.in_div;
  assign pll_vco_mul = cfg.vco_mul;
  assign pll_vco_div = cfg.vco_div;
  assign pll_factor = cfg.factor;
  assign wd_count = cnt_q;
endmodule : ocs_clock_select

// *** hdl/ocs_pkg.sv ***
// package of constants and types for the oscillator watchdog clock select block
// Overview of operation
// - watchdog enabled after reset by default
// - disable bit four turns watchdog off
// - enabled watchdog: pll ticks increment counter
// - each crystal transition clears the counter
// - counter overflows after sixteen pll ticks
// - overflow switches cpu clock, flags interrupt
// - switchover holds despite crystal returning
// - only reset restores direct clock source
// - disabled, non-pll code: crystal clock, pll powered off
// - supervision only in direct or prescaled modes
// - straps sampled in reset; codes other than 011 and 001 enable pll
// - pll resyncs on every f-th transition
// - codes 1xx: input /4, vco pairs
// - codes 010, 000: input /2, x10, x16
// - 011 bypasses pll; 001 halves input
// - code 001 uses prescaler divide by two
// - code 011 drives cpu from crystal pin
package ocs_pkg;
  localparam logic [2:0] STRAP_DIRECT = 3'h3; // direct drive code
  localparam logic [2:0] STRAP_PRESCALE = 3'h1; // prescaler code
  localparam int CFG_DIS_BIT = 4; // disable bit in system config word
  localparam logic [4:0] WD_OVF = 5'h10; // sixteen pll ticks
  localparam logic [4:0] WD_ZERO = 5'h00; // counter reset value
  localparam logic CFG_DIS_RST = 1'b0; // watchdog enabled at reset
  localparam logic [2:0] STRAP_RST = 3'h7; // default strap value
  localparam logic [7:0] PLL_DEF_MUL = 8'h40; // default vco multiply
  localparam logic [2:0] PLL_DEF_DIV = 3'h4; // default vco divide
  localparam logic [2:0] PLL_DEF_PRE = 3'h4; // default input divide
  localparam logic [4:0] PLL_DEF_F = 5'h04; // default factor
  // clock source selection states, gray along reset to external to fallback
  typedef enum logic [1:0] {
    CS_RESET = 2'b00,
    CS_EXT = 2'b01,
    CS_FREE = 2'b11
  } ocs_src_t;
  // decoded pll setting
  typedef struct packed {
    logic pll_on;
    logic presc_out;
    logic [2:0] in_div;
    logic [7:0] vco_mul;
    logic [2:0] vco_div;
    logic [4:0] factor;
  } ocs_pll_t;
endpackage : ocs_pkg

// *** hdl/ocs_wd_counter.sv ***
// watchdog counter clocked by the pll free-running tick
`timescale 1ns/1ps
module ocs_wd_counter
  import ocs_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // counter link
  ocs_wd_if.cnt wd
);
  logic [4:0] cnt_q; // tick count
  logic [4:0] cnt_d;
  logic ovf_q; // overflow pulse
  logic ovf_d;
  ////////////////////////////////////////////////////////////////////////////
  // next count
  always_comb begin
    cnt_d = cnt_q;
    ovf_d = 1'b0;
    if (!wd.run) begin
      cnt_d = WD_ZERO;
    end else if (wd.xtal_edge) begin
      cnt_d = WD_ZERO;
    end else if (cnt_q == WD_OVF - 5'h01) begin
      cnt_d = WD_ZERO;
      ovf_d = 1'b1;
    end else begin
      cnt_d = cnt_q + 5'h01;
    end
  end
  // register count
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cnt_q <= WD_ZERO;
      ovf_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      ovf_q <= ovf_d;
    end
  end
  assign wd.count = cnt_q;
  assign wd.ovf = ovf_q;
endmodule : ocs_wd_counter

// *** hdl/ocs_wd_if.sv ***
// interface carrying watchdog counter signals between the top and the counter
`timescale 1ns/1ps
interface ocs_wd_if;
  logic run; // counting enabled
  logic xtal_edge; // crystal transition seen
  logic ovf; // overflow pulse
  logic [4:0] count; // present count
  modport ctl (output run, output xtal_edge, input ovf, input count);
  modport cnt (input run, input xtal_edge, output ovf, output count);
endinterface : ocs_wd_if

// *** sim/ocs_chk.sv ***
// port assertions for the clock select block
`timescale 1ns/1ps
module ocs_chk
  import ocs_pkg::*;
(
  // clock, reset
  input wire logic mclk,
  input wire logic rst_n,
  // inputs
  input wire logic osc_supervisor_disable,
  input wire logic irq_clear,
  // outputs
  input wire logic owd_irq,
  input wire logic clk_switched,
  input wire logic pll_power_on,
  input wire logic use_pll,
  input wire logic cpu_clk_sel_free,
  input wire logic [4:0] wd_count
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sw_hold_a: assert property (clk_switched |=> clk_switched)
    else $error("switchover dropped");
  sw_irq_a: assert property ($rose(clk_switched) |-> owd_irq)
    else $error("switch without flag");
  sel_same_a: assert property (cpu_clk_sel_free == clk_switched)
    else $error("select differs from state");
  pll_no_sw_a: assert property (use_pll |-> !clk_switched)
    else $error("switch in pll mode");
  dis_no_sw_a: assert property (osc_supervisor_disable [*4] |=> !$rose(clk_switched))
    else $error("switch while disabled");
  irq_keep_a: assert property (owd_irq && !irq_clear |=> owd_irq)
    else $error("flag lost");
  pll_off_a: assert property ((osc_supervisor_disable && !use_pll) [*3] |-> !pll_power_on)
    else $error("pll on while disabled");
  cnt_max_a: assert property (wd_count < WD_OVF)
    else $error("count past overflow");
endmodule : ocs_chk
bind ocs_clock_select ocs_chk i_chk (.mclk(mclk), .rst_n(rst_n),
  .osc_supervisor_disable(osc_supervisor_disable), .irq_clear(irq_clear), .owd_irq(owd_irq),
  .clk_switched(clk_switched), .pll_power_on(pll_power_on), .use_pll(use_pll),
  .cpu_clk_sel_free(cpu_clk_sel_free), .wd_count(wd_count));

// *** sim/ocs_xtal_model.sv ***
// crystal source model: toggles while enabled, a stopped crystal holds its level
`timescale 1ns/1ps
module ocs_xtal_model (
  // clock and control
  input wire logic mclk,
  input wire logic en,
  input wire logic [2:0] half,
  // crystal pin
  output logic xtal = 1'b0
);
  logic [2:0] cnt_q = 3'h0; // cycles in the present half period
  // short half periods keep the input well inside its legal range
  always @(posedge mclk) begin
    if (en && (cnt_q + 3'h1 >= half)) begin
      xtal <= ~xtal;
      cnt_q <= 3'h0;
    end else if (en) begin
      cnt_q <= cnt_q + 3'h1;
    end
  end
endmodule : ocs_xtal_model

// *** sim/test_osc_watchdog_clock_select.sv ***
// self-checking bench for the clock select block
`timescale 1ns/1ps
module test_osc_watchdog_clock_select
  import ocs_pkg::*;
;
  logic mclk = 1'b0, rst_n = 1'b0, xen = 1'b1, dis = 1'b0, clr = 1'b0, chk = 1'b0; // drive
  logic [2:0] straps = 3'h7, half = 3'h2; // strap code, crystal half period
  logic [31:0] lfsr = 32'h5777; // random source
  logic irq, sw, pwr, upll, upre, sel, xtal; // status and pin
  logic [2:0] idiv, vdiv; // dividers
  logic [7:0] vmul; // vco multiply
  logic [4:0] fac, cnt; // factor, counter copy
  logic [47:0] note_q[$]; // expected mask and value
  logic [47:0] nt; // note under compare
  int num_errors, total_checks; // verdict counters
  wire [23:0] got = {irq, sw, upll, upre, pwr, idiv, vmul, vdiv, fac};
  ocs_clock_select i_dut (.mclk(mclk), .rst_n(rst_n), .crystal_input(xtal),
    .clock_mode_straps(straps), .osc_supervisor_disable(dis), .irq_clear(clr), .owd_irq(irq),
    .clk_switched(sw), .pll_power_on(pwr), .use_pll(upll), .use_prescaler(upre),
    .cpu_clk_sel_free(sel), .pll_in_div(idiv), .pll_vco_mul(vmul), .pll_vco_div(vdiv),
    .pll_factor(fac), .wd_count(cnt));
  ocs_xtal_model i_xtal (.mclk(mclk), .en(xen), .half(half), .xtal(xtal));
  initial begin
    forever #10 mclk = ~mclk;
  end
  // expected mask and value; pll fields only compared in pll modes
  function automatic logic [47:0] dec(input logic [2:0] s, input logic i, w, p);
    logic [18:0] f;
    logic u;
    u = (s != STRAP_DIRECT) && (s != STRAP_PRESCALE);
    case (s)
      3'h7: f = {3'h4, 8'h40, 3'h4, 5'h04};
      3'h6: f = {3'h4, 8'h30, 3'h4, 5'h03};
      3'h5: f = {3'h4, 8'h40, 3'h2, 5'h08};
      3'h4: f = {3'h4, 8'h28, 3'h2, 5'h05};
      3'h2: f = {3'h2, 8'h28, 3'h2, 5'h0a};
      3'h0: f = {3'h2, 8'h40, 3'h2, 5'h10};
      default: f = 19'h0;
    endcase
    return {5'h1f, u ? 19'h7ffff : 19'h0, i, w, u, s == STRAP_PRESCALE, p, f};
  endfunction : dec
  // next value of the bench's random source
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr_next
  task cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask : cyc
  // reset with straps and a random crystal half period of 1 to 4
  task rst(input logic [2:0] s);
    @(posedge mclk);
    lfsr = lfsr_next(lfsr);
    rst_n <= 1'b0;
    straps <= s;
    half <= {1'b0, lfsr[1:0]} + 3'h1;
    cyc(16);
    rst_n <= 1'b1;
  endtask : rst
  // note an expectation and strobe the monitor
  task note(input logic [47:0] n);
    @(posedge mclk);
    note_q.push_back(n);
    chk <= 1'b1;
    @(posedge mclk);
    chk <= 1'b0;
  endtask : note
  task finish_test;
    if (num_errors == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : finish_test
  // monitor: compares status with the oldest note
  always @(posedge mclk) begin
    if (chk === 1'b1) begin
      nt = note_q.pop_front();
      total_checks++;
      if ((got & nt[47:24]) !== (nt[23:0] & nt[47:24])) begin
        num_errors++;
        $display("MISMATCH %0t status %h expected %h", $time, got, nt[23:0]);
      end
    end
  end
  initial begin
    for (int s = 0; s < 8; s++) begin
      rst(s[2:0]);
      cyc(40);
      note(dec(s[2:0], 1'b0, 1'b0, 1'b1));
    end
    rst(STRAP_DIRECT);
    cyc(30);
    xen <= 1'b0;
    cyc(12);
    note(dec(STRAP_DIRECT, 1'b0, 1'b0, 1'b1));
    for (int i = 0; i < 40 && sw !== 1'b1; i++) @(posedge mclk);
    if (sw !== 1'b1) begin
      num_errors++;
      $display("MISMATCH %0t no switchover", $time);
      finish_test();
    end
    note(dec(STRAP_DIRECT, 1'b1, 1'b1, 1'b1));
    xen <= 1'b1;
    cyc(40);
    note(dec(STRAP_DIRECT, 1'b1, 1'b1, 1'b1));
    clr <= 1'b1;
    cyc(1);
    clr <= 1'b0;
    cyc(2);
    note(dec(STRAP_DIRECT, 1'b0, 1'b1, 1'b1));
    rst(STRAP_DIRECT);
    cyc(4);
    note(dec(STRAP_DIRECT, 1'b0, 1'b0, 1'b1));
    rst(STRAP_PRESCALE);
    dis <= 1'b1;
    cyc(4);
    xen <= 1'b0;
    cyc(60);
    note(dec(STRAP_PRESCALE, 1'b0, 1'b0, 1'b0));
    dis <= 1'b0;
    rst(3'h7);
    cyc(60);
    note(dec(3'h7, 1'b0, 1'b0, 1'b1));
    cyc(2);
    finish_test();
  end
endmodule : test_osc_watchdog_clock_select
